// File: rtl/ccdr_pkg.sv
// Shared constants and carriers for the control-channel register bank.
// Assumes one 100 MHz core clock and byte writes delivered by the frame logic.
package ccdr_pkg;

    // ------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------
    localparam int          BYTE_W       = 8;
    localparam int          SEL_LO_BIT   = 0;
    localparam int          SEL_HI_BIT   = 1;
    localparam int          DIAG_CLR_BIT = 2;
    localparam int          RATE_BIT     = 3;
    localparam int          BEARER_BIT   = 4;
    localparam int          PSAVE_BIT    = 5;
    localparam int          FAST_BIT     = 6;
    localparam int          HK_BIT       = 7;
    localparam int          LOOP_LO_BIT  = 2;
    localparam int          LOOP_HI_BIT  = 3;
    localparam int          UNSYNC_BIT   = 4;
    localparam int          POLYNOMIAL_SWAP_BIT    = 5;
    localparam int          LINE_TX_OUT_DIS_BIT = 6;

    // ------------------------------------------------------------
    // Default modes and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  DEFAULT_MASK = 8'hF0;
    localparam logic [7:0]  MODE1_WORD   = 8'h00;
    localparam logic [7:0]  MODE2_WORD   = 8'h08;
    localparam logic [7:0]  CTL_RESET    = 8'h00;
    localparam logic [7:0]  DIAG_RESET   = 8'h00;

    // Adaptation step shift of the echo canceller (smaller is faster)
    localparam logic [2:0]  ADAPT_FAST   = 3'h2;
    localparam logic [2:0]  ADAPT_NORMAL = 3'h6;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LOOP_NONE,
        LOOP_SYS,
        LOOP_LINE,
        LOOP_END
    } ccdr_loop_e;

    typedef struct packed {
        logic       housekeepingTxBit;
        logic       fastConverge;
        logic       powerSaveEnable;
        logic       signallingInBearer;
        logic       lineRateSelect;
        logic [2:0] adaptShift;
    } ccdr_line_cfg_s;

    typedef struct packed {
        ccdr_loop_e loopSel;
        logic       forceUnsync;
        logic       polynomialSwap;
        logic       lineOutDisable;
    } ccdr_diag_cfg_s;

    typedef struct packed {
        logic       stage1;
        logic       stage2;
    } ccdr_sync_s;

    typedef struct packed {
        logic [7:0]     lineControlWord;
        logic [7:0]     diagnosticControlWord;
        logic [7:0]     pendByte;
        logic           pendValid;
        logic           pinAllLow;
        logic           pinAllHigh;
        ccdr_line_cfg_s lineCfg;
        ccdr_diag_cfg_s diagCfg;
        logic           lineTxBias;
    } ccdr_state_s;

endpackage

// File: rtl/ccdr_sync2.sv
// Two-stage synchroniser for a single pin level.
// Assumes the pin is asynchronous to core_clk; only stage2 is used outside.
`timescale 1ns/10ps

module ccdr_sync2 (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic resetn,
    // Pin and synchronised level
    input  wire logic pinLevel,
    output logic      syncLevel
);

    ccdr_pkg::ccdr_sync_s state_q;
    ccdr_pkg::ccdr_sync_s state_d;

    always_comb begin
        state_d        = state_q;
        state_d.stage1 = pinLevel;
        state_d.stage2 = state_q.stage1;
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign syncLevel = state_q.stage2;

endmodule

// File: rtl/ccdr_diag_decode.sv
// Decodes a diagnostic control word into loopback and test controls.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps

module ccdr_diag_decode (
    // Stored diagnostic word
    input  wire logic [7:0]          diagWord,
    // Decoded controls
    output ccdr_pkg::ccdr_diag_cfg_s diagCfg
);

    function automatic ccdr_pkg::ccdr_loop_e decodeLoop(input logic lo, input logic hi);
        ccdr_pkg::ccdr_loop_e sel;
        sel = ccdr_pkg::LOOP_NONE;
        case ({lo, hi})
            2'h0:    sel = ccdr_pkg::LOOP_NONE;
            2'h1:    sel = ccdr_pkg::LOOP_SYS;
            2'h2:    sel = ccdr_pkg::LOOP_LINE;
            2'h3:    sel = ccdr_pkg::LOOP_END;
            default: sel = ccdr_pkg::LOOP_NONE;
        endcase
        return sel;
    endfunction

    always_comb begin
        diagCfg.loopSel        = decodeLoop(diagWord[ccdr_pkg::LOOP_LO_BIT],
                                            diagWord[ccdr_pkg::LOOP_HI_BIT]);
        diagCfg.forceUnsync    = diagWord[ccdr_pkg::UNSYNC_BIT];
        diagCfg.polynomialSwap = diagWord[ccdr_pkg::POLYNOMIAL_SWAP_BIT];
        diagCfg.lineOutDisable = diagWord[ccdr_pkg::LINE_TX_OUT_DIS_BIT];
    end

endmodule

// File: rtl/ccdr_top.sv
// Control and diagnostic register bank of a twisted-pair line transceiver.
// Assumes control-channel bytes and the frame pulse come from framing logic
// on core_clk; the control pin and line-out disable pin are asynchronous.
//
// Notes on behaviour
// - Fast converge bit speeds echo canceller adaptation
// - Bits 4-7 all ones select default mode
// - Pattern XXX01111 loads control word 00000000
// - Pattern XXX11111 loads control word 00010000
// - Constant control pin selects default mode in separate-port mode
// - Diagnostic bits 2,3 choose the loopback path
// - Diagnostic bit 4 forces loss of sync
// - Diagnostic bit 5 swaps scrambler polynomials
// - Diagnostic bit 6 holds line output at bias
// - Select bits 0,0 steer byte to control
// - Control bit 2 zero clears diagnostics
`timescale 1ns/10ps

module ccdr_top (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                resetn,
    // Control channel from frame logic
    input  wire logic [7:0]          ctlByte,
    input  wire logic                ctlByteValid,
    input  wire logic                framePulse,
    // Mode and pins
    input  wire logic                separatePortMode,
    input  wire logic                controlSerialIn,
    input  wire logic                lineOutDisablePin,
    // Configuration to the transceiver core
    output ccdr_pkg::ccdr_line_cfg_s lineCfg,
    output ccdr_pkg::ccdr_diag_cfg_s diagCfg,
    output logic                     lineTxBias
);

    // ------------------------------------------------------------
    // Pin synchronisers and diagnostic decode
    // ------------------------------------------------------------
    logic                     ctlPinSync;
    logic                     loutDisSync;
    ccdr_pkg::ccdr_diag_cfg_s diagNext;
    ccdr_pkg::ccdr_state_s    state_q;
    ccdr_pkg::ccdr_state_s    state_d;

    ccdr_sync2 u_ctl_pin_sync (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .pinLevel  (controlSerialIn),
        .syncLevel (ctlPinSync)
    );

    ccdr_sync2 u_line_tx_out_dis_sync (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .pinLevel  (lineOutDisablePin),
        .syncLevel (loutDisSync)
    );

    ccdr_diag_decode u_diag_decode (
        .diagWord (state_q.diagnosticControlWord),
        .diagCfg  (diagNext)
    );

    // ------------------------------------------------------------
    // Byte classification
    // ------------------------------------------------------------
    function automatic logic isDefault(input logic [7:0] b);
        return (b & ccdr_pkg::DEFAULT_MASK) == ccdr_pkg::DEFAULT_MASK;
    endfunction

    function automatic logic isCtlSel(input logic [7:0] b);
        return !b[ccdr_pkg::SEL_LO_BIT] && !b[ccdr_pkg::SEL_HI_BIT];
    endfunction

    function automatic logic isDiagSel(input logic [7:0] b);
        return !b[ccdr_pkg::SEL_LO_BIT] && b[ccdr_pkg::SEL_HI_BIT];
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic pinConstLow;
    logic pinConstHigh;

    always_comb begin
        state_d      = state_q;
        pinConstLow  = state_q.pinAllLow && !ctlPinSync;
        pinConstHigh = state_q.pinAllHigh && ctlPinSync;

        // Pin constancy tracked per frame, restarted at each frame pulse
        if (framePulse) begin
            state_d.pinAllLow  = 1'b1;
            state_d.pinAllHigh = 1'b1;
        end else begin
            state_d.pinAllLow  = pinConstLow;
            state_d.pinAllHigh = pinConstHigh;
        end

        if (framePulse) begin
            state_d.pendValid = 1'b0;
            if (separatePortMode && (pinConstLow || pinConstHigh)) begin
                state_d.lineControlWord       = pinConstHigh ? ccdr_pkg::MODE2_WORD
                                                             : ccdr_pkg::MODE1_WORD;
                state_d.diagnosticControlWord = ccdr_pkg::DIAG_RESET;
            end else if (state_q.pendValid) begin
                if (isDefault(state_q.pendByte)) begin
                    // Default modes carry a zero clear bit, so diagnostics drop too
                    state_d.lineControlWord       = state_q.pendByte[ccdr_pkg::RATE_BIT]
                                                    ? ccdr_pkg::MODE2_WORD
                                                    : ccdr_pkg::MODE1_WORD;
                    state_d.diagnosticControlWord = ccdr_pkg::DIAG_RESET;
                end else if (isCtlSel(state_q.pendByte)) begin
                    state_d.lineControlWord = state_q.pendByte;
                    if (!state_q.pendByte[ccdr_pkg::DIAG_CLR_BIT]) begin
                        state_d.diagnosticControlWord = ccdr_pkg::DIAG_RESET;
                    end
                end else if (isDiagSel(state_q.pendByte)) begin
                    state_d.diagnosticControlWord = state_q.pendByte;
                end
            end
        end

        // A byte arriving with the frame pulse waits for the next frame
        if (ctlByteValid) begin
            state_d.pendByte  = ctlByte;
            state_d.pendValid = 1'b1;
        end

        // Outputs other than lineTxBias are registered copies of the stored words
        state_d.lineCfg.housekeepingTxBit  = state_q.lineControlWord[ccdr_pkg::HK_BIT];
        state_d.lineCfg.fastConverge       = state_q.lineControlWord[ccdr_pkg::FAST_BIT];
        state_d.lineCfg.powerSaveEnable    = state_q.lineControlWord[ccdr_pkg::PSAVE_BIT];
        state_d.lineCfg.signallingInBearer = state_q.lineControlWord[ccdr_pkg::BEARER_BIT];
        state_d.lineCfg.lineRateSelect     = state_q.lineControlWord[ccdr_pkg::RATE_BIT];
        state_d.lineCfg.adaptShift         = state_q.lineControlWord[ccdr_pkg::FAST_BIT]
                                             ? ccdr_pkg::ADAPT_FAST
                                             : ccdr_pkg::ADAPT_NORMAL;
        state_d.diagCfg                    = diagNext;
        // The pin and the register bit both park the driver at bias
        state_d.lineTxBias                 = diagNext.lineOutDisable || loutDisSync;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_q                       <= '0;
            state_q.lineControlWord       <= ccdr_pkg::CTL_RESET;
            state_q.diagnosticControlWord <= ccdr_pkg::DIAG_RESET;
            state_q.pinAllLow             <= 1'b1;
            state_q.pinAllHigh            <= 1'b1;
            state_q.lineCfg.adaptShift    <= ccdr_pkg::ADAPT_NORMAL;
        end else begin
            state_q <= state_d;
        end
    end

    assign lineCfg    = state_q.lineCfg;
    assign diagCfg    = state_q.diagCfg;
    assign lineTxBias = state_q.lineTxBias;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    logic frameTakes;
    assign frameTakes = framePulse && state_q.pendValid && !separatePortMode;

    a_default_mode1: assert property (
        frameTakes && isDefault(state_q.pendByte) && !state_q.pendByte[ccdr_pkg::RATE_BIT]
        |=> state_q.lineControlWord == ccdr_pkg::MODE1_WORD
    ) else $error("default mode 1 not loaded");

    a_default_mode2: assert property (
        frameTakes && isDefault(state_q.pendByte) && state_q.pendByte[ccdr_pkg::RATE_BIT]
        |=> state_q.lineControlWord == ccdr_pkg::MODE2_WORD
    ) else $error("default mode 2 not loaded");

    a_ctl_select: assert property (
        frameTakes && !isDefault(state_q.pendByte) && isCtlSel(state_q.pendByte)
        |=> state_q.lineControlWord == $past(state_q.pendByte)
    ) else $error("control byte not stored");

    a_diag_select: assert property (
        frameTakes && !isDefault(state_q.pendByte) && isDiagSel(state_q.pendByte)
        |=> state_q.diagnosticControlWord == $past(state_q.pendByte)
            && $stable(state_q.lineControlWord)
    ) else $error("diagnostic byte misrouted");

    a_diag_clear: assert property (
        frameTakes && isCtlSel(state_q.pendByte)
        && !state_q.pendByte[ccdr_pkg::DIAG_CLR_BIT]
        |=> state_q.diagnosticControlWord == ccdr_pkg::DIAG_RESET
    ) else $error("diagnostics not cleared");

    a_frame_hold: assert property (
        !framePulse |=> $stable(state_q.lineControlWord)
                        && $stable(state_q.diagnosticControlWord)
    ) else $error("register changed between frames");

    a_pin_default: assert property (
        framePulse && separatePortMode && state_q.pinAllHigh && ctlPinSync
        |=> state_q.lineControlWord == ccdr_pkg::MODE2_WORD
    ) else $error("pin default mode not applied");

    a_fast_adapt: assert property (
        state_q.lineControlWord[ccdr_pkg::FAST_BIT] && $stable(state_q.lineControlWord)
        |=> lineCfg.adaptShift == ccdr_pkg::ADAPT_FAST && lineCfg.fastConverge
    ) else $error("fast adaptation not selected");

    a_loop_path: assert property (
        state_q.diagnosticControlWord[ccdr_pkg::LOOP_HI_BIT:ccdr_pkg::LOOP_LO_BIT] == 2'h2
        |=> diagCfg.loopSel == ccdr_pkg::LOOP_SYS
    ) else $error("loopback path wrong");

    a_line_bias: assert property (
        state_q.diagnosticControlWord[ccdr_pkg::LINE_TX_OUT_DIS_BIT] |=> lineTxBias
    ) else $error("line output not held at bias");

    a_hk_bit: assert property (
        ##1 lineCfg.housekeepingTxBit == $past(state_q.lineControlWord[ccdr_pkg::HK_BIT])
    ) else $error("housekeeping bit mismatch");

    a_pin_mode1: assert property (
        framePulse && separatePortMode && state_q.pinAllLow && !ctlPinSync
        |=> state_q.lineControlWord == ccdr_pkg::MODE1_WORD
            && state_q.diagnosticControlWord == ccdr_pkg::DIAG_RESET
    ) else $error("pin default mode 1 not applied");

    a_pin_discard: assert property (
        framePulse && separatePortMode && state_q.pinAllHigh && ctlPinSync && !ctlByteValid
        |=> !state_q.pendValid
    ) else $error("pending byte kept over pin default");

    a_defer_byte: assert property (
        framePulse && ctlByteValid
        |=> state_q.pendValid && state_q.pendByte == $past(ctlByte)
    ) else $error("byte with frame pulse not deferred");

    a_adapt_normal: assert property (
        !state_q.lineControlWord[ccdr_pkg::FAST_BIT]
        |=> lineCfg.adaptShift == ccdr_pkg::ADAPT_NORMAL && !lineCfg.fastConverge
    ) else $error("normal adaptation not selected");

    a_rate_select: assert property (
        ##1 lineCfg.lineRateSelect == $past(state_q.lineControlWord[ccdr_pkg::RATE_BIT])
    ) else $error("line rate select mismatch");

    a_loop_line: assert property (
        state_q.diagnosticControlWord[ccdr_pkg::LOOP_HI_BIT:ccdr_pkg::LOOP_LO_BIT] == 2'h1
        |=> diagCfg.loopSel == ccdr_pkg::LOOP_LINE
    ) else $error("line loopback path wrong");

    a_loop_end: assert property (
        state_q.diagnosticControlWord[ccdr_pkg::LOOP_HI_BIT:ccdr_pkg::LOOP_LO_BIT] == 2'h3
        |=> diagCfg.loopSel == ccdr_pkg::LOOP_END
    ) else $error("end-to-end loopback path wrong");

    a_loop_none: assert property (
        state_q.diagnosticControlWord[ccdr_pkg::LOOP_HI_BIT:ccdr_pkg::LOOP_LO_BIT] == 2'h0
        |=> diagCfg.loopSel == ccdr_pkg::LOOP_NONE
    ) else $error("loopback active in normal operation");

    a_force_unsync: assert property (
        ##1 diagCfg.forceUnsync == $past(state_q.diagnosticControlWord[ccdr_pkg::UNSYNC_BIT])
    ) else $error("force unsync mismatch");

    a_poly_swap: assert property (
        ##1 diagCfg.polynomialSwap == $past(state_q.diagnosticControlWord[ccdr_pkg::POLYNOMIAL_SWAP_BIT])
    ) else $error("polynomial swap mismatch");

    a_bias_release: assert property (
        !state_q.diagnosticControlWord[ccdr_pkg::LINE_TX_OUT_DIS_BIT] && !loutDisSync |=> !lineTxBias
    ) else $error("line output held at bias while enabled");

    a_diag_keep: assert property (
        frameTakes && !isDefault(state_q.pendByte) && isCtlSel(state_q.pendByte)
        && state_q.pendByte[ccdr_pkg::DIAG_CLR_BIT]
        |=> $stable(state_q.diagnosticControlWord)
    ) else $error("diagnostics cleared although clear bit set");

    a_drop_byte: assert property (
        frameTakes && !isDefault(state_q.pendByte) && state_q.pendByte[ccdr_pkg::SEL_LO_BIT]
        |=> $stable(state_q.lineControlWord) && $stable(state_q.diagnosticControlWord)
    ) else $error("unselected byte changed a register");

endmodule

// File: tb/ccdr_ctl_model.sv
// Behavioural system controller that writes control-channel bytes.
// Assumes the bench clock; drives on the falling edge only.
`timescale 1ns/10ps

module ccdr_ctl_model (
    // Clock
    input  wire logic core_clk,
    // Control channel
    output logic [7:0] ctlByte,
    output logic       ctlByteValid,
    output logic       framePulse
);
    initial begin
        ctlByte = 8'h00;
        ctlByteValid = 1'b0;
        framePulse = 1'b0;
    end

    // Released byte lines show the inverse so stale data is never mistaken
    task automatic sendByte(input logic [7:0] b, input logic withPulse);
        logic [7:0] v;
        v = b;
        if (v[1:0] == 2'h2 && v[7:4] != 4'hF) begin
            v[7] = 1'b0;
        end
        @(negedge core_clk);
        ctlByte = v;
        ctlByteValid = 1'b1;
        framePulse = withPulse;
        @(negedge core_clk);
        ctlByte = ~v;
        ctlByteValid = 1'b0;
        framePulse = 1'b0;
    endtask

    task automatic frame();
        @(negedge core_clk);
        framePulse = 1'b1;
        @(negedge core_clk);
        framePulse = 1'b0;
    endtask

    // Hold fast convergence through the start-up frames for the rate
    task automatic startup(input logic rate160);
        int n;
        n = rate160 ? 240 : 480;
        for (int i = 0; i < n; i++) begin
            sendByte({4'h4, rate160, 3'h4}, 1'b0);
            frame();
        end
    endtask
endmodule

// File: tb/test_ccdr_top.sv
// Self-checking bench for the control and diagnostic register bank.
// Assumes the partner model owns the control channel; pins come from here.
`timescale 1ns/10ps

module test_ccdr_top;
    logic                     core_clk;
    logic                     resetn;
    logic                     separatePortMode;
    logic                     controlSerialIn;
    logic                     lineOutDisablePin;
    logic [7:0]               ctlByte;
    logic                     ctlByteValid;
    logic                     framePulse;
    ccdr_pkg::ccdr_line_cfg_s lineCfg;
    ccdr_pkg::ccdr_diag_cfg_s diagCfg;
    logic                     lineTxBias;
    logic [7:0]               expCtl;
    logic [7:0]               expDiag;
    logic [7:0]               pend;
    logic                     pendV;
    logic [7:0]               b;
    int                       nErrors;
    int                       checkCount;
    int                       cycles;
    localparam logic [39:0]   DEF_PAT = 40'hF0F8F3FEF7;

    ccdr_top ccdr_top_inst (
        .core_clk(core_clk), .resetn(resetn), .ctlByte(ctlByte),
        .ctlByteValid(ctlByteValid), .framePulse(framePulse),
        .separatePortMode(separatePortMode), .controlSerialIn(controlSerialIn),
        .lineOutDisablePin(lineOutDisablePin), .lineCfg(lineCfg),
        .diagCfg(diagCfg), .lineTxBias(lineTxBias)
    );

    ccdr_ctl_model ccdr_ctl_model_inst (
        .core_clk(core_clk), .ctlByte(ctlByte), .ctlByteValid(ctlByteValid),
        .framePulse(framePulse)
    );

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic logic [13:0] expOut(input logic [7:0] c, input logic [7:0] d,
                                           input logic pin);
        return {c[7], c[6], c[5], c[4], c[3],
                c[6] ? ccdr_pkg::ADAPT_FAST : ccdr_pkg::ADAPT_NORMAL,
                d[2], d[3], d[4], d[5], d[6], d[6] | pin};
    endfunction

    // Default pattern wins over select bits; bit0 set drops the byte
    task automatic applyByte(input logic [7:0] v);
        if (v[7:4] == 4'hF) begin
            expCtl = v[3] ? 8'h08 : 8'h00;
            expDiag = 8'h00;
        end else if (v[1:0] == 2'h0) begin
            expCtl = v;
            if (!v[2]) begin
                expDiag = 8'h00;
            end
        end else if (v[1:0] == 2'h2) begin
            expDiag = v;
        end
    endtask

    // Byte waits for the first pulse after its capture edge
    always @(posedge core_clk) begin
        cycles++;
        if (!resetn) begin
            expCtl = 8'h00;
            expDiag = 8'h00;
            pendV = 1'b0;
        end else begin
            if (framePulse && pendV) begin
                applyByte(pend);
                pendV = 1'b0;
            end
            if (ctlByteValid) begin
                pend = ctlByte;
                pendV = 1'b1;
            end
        end
        if (cycles == 20000) begin
            nErrors++;
            reportAndStop();
        end
    end

    task automatic checkOut();
        logic [13:0] e;
        logic [13:0] g;
        repeat (3) @(negedge core_clk);
        e = expOut(expCtl, expDiag, lineOutDisablePin);
        g = {lineCfg, diagCfg, lineTxBias};
        checkCount++;
        if (g !== e) begin
            nErrors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic put(input logic [7:0] v);
        ccdr_ctl_model_inst.sendByte(v, 1'b0);
        ccdr_ctl_model_inst.frame();
        checkOut();
    endtask

    task automatic reportAndStop();
        $display("checks=%0d errors=%0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always #5 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        separatePortMode = 1'b0;
        controlSerialIn = 1'b0;
        lineOutDisablePin = 1'b0;
        nErrors = 0;
        checkCount = 0;
        cycles = 0;
        void'($urandom(46555));
        repeat (12) @(negedge core_clk);
        resetn = 1'b1;
        checkOut();
        for (int r = 1; r >= 0; r--) begin
            ccdr_ctl_model_inst.startup(r[0]);
            checkOut();
            put({4'h0, r[0], 3'h4});
        end
        // Each loopback code is rewritten in successive frames
        for (int c = 0; c < 4; c++) begin
            put({4'h7, c[0], c[1], 2'h2});
        end
        put(8'h84);
        put(8'h80);
        for (int i = 0; i < 5; i++) begin
            put(8'h72);
            put(DEF_PAT[8*i +: 8]);
        end
        put(8'hC9);
        ccdr_ctl_model_inst.sendByte(8'h80, 1'b0);
        ccdr_ctl_model_inst.sendByte(8'h48, 1'b0);
        put(8'h4C);
        ccdr_ctl_model_inst.sendByte(8'hC8, 1'b1);
        checkOut();
        ccdr_ctl_model_inst.frame();
        checkOut();
        // Constant control pin in separate-port operation
        for (int p = 1; p >= 0; p--) begin
            put(8'hC8);
            separatePortMode = 1'b1;
            controlSerialIn = p[0];
            ccdr_ctl_model_inst.frame();
            ccdr_ctl_model_inst.sendByte(8'h80, 1'b0);
            ccdr_ctl_model_inst.frame();
            expCtl = p[0] ? 8'h08 : 8'h00;
            expDiag = 8'h00;
            checkOut();
            separatePortMode = 1'b0;
        end
        // Random traffic, from zero to two bytes a frame
        for (int i = 0; i < 80; i++) begin
            lineOutDisablePin = 1'($urandom);
            controlSerialIn = 1'($urandom);
            repeat ($urandom % 3) begin
                b = 8'($urandom);
                b[0] = ($urandom % 5 == 0);
                ccdr_ctl_model_inst.sendByte(b, 1'b0);
            end
            ccdr_ctl_model_inst.frame();
            checkOut();
        end
        reportAndStop();
    end
endmodule
